// [cocc_checker.sv]
// capability checks for cache-block management, zero and prefetch operations
`default_nettype none
module cocc_checker import cocc_pkg::*; #(
	parameter int  CBLK_BYTES_P       = CBLK_BYTES,
	parameter int  CAP_WIDTH_P        = CAP_W_BITS,
	parameter bit  ALWAYS_INVAL_FLUSH = 1'b1
) (
	input  wire logic        sys_clk_in,
	input  wire logic        rst_b_in,
	input  wire cocc_req_t   req_in,
	input  wire logic        mem_ready_in,
	output logic             req_ready_out,
	output cocc_mem_t        mem_out,
	output logic             done_out,
	output cocc_exc_t        exc_out,
	output logic             pref_dropped_out
);
	localparam int CAP_BYTES = CAP_WIDTH_P / 8;
	localparam int BEATS     = CBLK_BYTES_P / CAP_BYTES;
	localparam int CNT_W     = (BEATS > 1) ? $clog2(BEATS) : 1;
	localparam int BLK_SH    = $clog2(CBLK_BYTES_P);
	localparam int CAP_SH    = $clog2(CAP_BYTES);

	typedef enum logic [1:0] {
		COCC_ST_IDLE = 2'b00,
		COCC_ST_ISSUE = 2'b01,
		COCC_ST_ZERO = 2'b10
	} cocc_state_t;

	typedef struct packed {
		cocc_state_t       state;
		logic [CNT_W-1:0]  beat;
		logic [ADDR_W-1:0] blk;
		cocc_mem_t         mem;
		logic              ready;
		logic              done;
		cocc_exc_t         exc;
		logic              dropped;
	} cocc_st_t;

	logic     rst_meta_reg;
	logic     rst_sync_reg;
	cocc_st_t st_reg;
	cocc_st_t st_next;

	always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			rst_meta_reg <= 1'b0;
			rst_sync_reg <= 1'b0;
		end else begin
			rst_meta_reg <= 1'b1;
			rst_sync_reg <= rst_meta_reg;
		end
	end

	logic [ADDR_W-1:0] ea;
	logic [ADDR_W-1:0] blk_lo;
	logic [ADDR_W-1:0] blk_hi;
	logic              any_in;
	logic              all_in;
	logic              cap_basic_ok;
	logic              is_pref;
	logic              pref_ok;
	logic              blk_fail;
	logic              ill;
	cocc_cmd_t         blk_cmd;
	logic              is_clean;
	logic              is_inval;
	logic              is_zero;
	logic              imm_ok;
	logic              perm_rw;
	logic              zero_aligned;
	logic              zero_tag_fault;
	logic              inval_to_flush;

	cocc_op_decode u_cocc_op_decode (
		.op_in       (req_in.op),
		.pref_out    (is_pref),
		.clean_out   (is_clean),
		.inval_out   (is_inval),
		.zero_out    (is_zero)
	);

	cocc_span_cmp #(
		.ADDR_W_P(ADDR_W)
	) u_cocc_span_cmp (
		.lo_in       (blk_lo),
		.hi_in       (blk_hi),
		.base_in     (req_in.cap.base),
		.top_in      (req_in.cap.top),
		.decodable_in(req_in.cap.bounds_ok),
		.any_out     (any_in),
		.all_out     (all_in)
	);

	cocc_pref_gate u_cocc_pref_gate (
		.op_in       (req_in.op),
		.cap_ok_in   (cap_basic_ok),
		.any_in      (any_in),
		.imm_ok_in   (imm_ok),
		.perm_r_in   (req_in.cap.perm_r),
		.perm_w_in   (req_in.cap.perm_w),
		.perm_x_in   (req_in.cap.perm_x),
		.ok_out      (pref_ok)
	);

	assign imm_ok         = req_in.imm[IMM_LOW_W-1:0] == IMM_LOW_ZERO;
	assign perm_rw        = req_in.cap.perm_r && req_in.cap.perm_w;
	assign zero_aligned   = ea[CAP_SH-1:0] == '0;
	assign zero_tag_fault = req_in.zero_store_tag && req_in.pma_tag_fault;
	assign inval_to_flush = ALWAYS_INVAL_FLUSH
		|| (req_in.less_priv && req_in.inval_as_flush_csr);

	always_comb begin
		if (is_pref) begin
			ea = req_in.cap.address + {{(ADDR_W-IMM_W){req_in.imm[IMM_W-1]}}, req_in.imm};
		end else begin
			ea = req_in.cap.address;
		end
		blk_lo = {ea[ADDR_W-1:BLK_SH], {BLK_SH{1'b0}}};
		blk_hi = blk_lo + ADDR_W'(CBLK_BYTES_P);
		cap_basic_ok = req_in.cap.tag && !req_in.cap.sealed
			&& req_in.cap.integrity_ok;
		ill = is_inval && !req_in.pc_system_register_access_perm;
		blk_fail = !cap_basic_ok;
		blk_cmd = COCC_CMD_NONE;
		case (req_in.op)
			COCC_OP_CLEAN, COCC_OP_FLUSH: begin
				blk_fail = blk_fail || !perm_rw
					|| !any_in;
				blk_cmd = is_clean ? COCC_CMD_CLEAN : COCC_CMD_FLUSH;
			end
			COCC_OP_INVAL: begin
				blk_fail = blk_fail || !perm_rw
					|| !all_in;
				if (inval_to_flush) begin
					blk_cmd = COCC_CMD_FLUSH;
				end else begin
					blk_cmd = COCC_CMD_INVAL;
				end
			end
			COCC_OP_ZERO: begin
				blk_fail = blk_fail || !req_in.cap.perm_w || !all_in
					|| !zero_aligned
					|| zero_tag_fault;
				blk_cmd = COCC_CMD_ZERO;
			end
			default: begin
				blk_fail = 1'b0;
				blk_cmd  = COCC_CMD_NONE;
			end
		endcase
	end

	always_comb begin
		st_next = st_reg;
		st_next.done = 1'b0;
		st_next.dropped = 1'b0;
		st_next.exc = COCC_EXC_NONE;
		case (st_reg.state)
			COCC_ST_IDLE: begin
				st_next.mem.valid = 1'b0;
				if (req_in.valid && st_reg.ready) begin
					if (is_pref) begin
						// hints finish without any exception
						st_next.done = 1'b1;
						if (pref_ok) begin
							st_next.mem.valid = 1'b1;
							st_next.mem.cmd = COCC_CMD_PREF;
							st_next.mem.addr = ea;
							st_next.mem.clear_tag = 1'b0;
							st_next.state = COCC_ST_ISSUE;
							st_next.ready = 1'b0;
							st_next.done = 1'b0;
						end else begin
							st_next.dropped = 1'b1;
						end
					end else if (ill) begin
						st_next.done = 1'b1;
						st_next.exc = COCC_EXC_ILL;
					end else if (blk_fail) begin
						st_next.done = 1'b1;
						st_next.exc = COCC_EXC_STORE;
					end else if (is_zero) begin
						st_next.blk = blk_lo;
						st_next.beat = '0;
						st_next.mem.valid = 1'b1;
						st_next.mem.cmd = COCC_CMD_ZERO;
						st_next.mem.addr = blk_lo;
						st_next.mem.clear_tag = 1'b1;
						st_next.state = COCC_ST_ZERO;
						st_next.ready = 1'b0;
					end else begin
						st_next.mem.valid = 1'b1;
						st_next.mem.cmd = blk_cmd;
						st_next.mem.addr = ea;
						st_next.mem.clear_tag = 1'b0;
						st_next.state = COCC_ST_ISSUE;
						st_next.ready = 1'b0;
					end
				end
			end
			COCC_ST_ISSUE: begin
				if (mem_ready_in) begin
					st_next.mem.valid = 1'b0;
					st_next.done = (st_reg.mem.cmd != COCC_CMD_PREF);
					st_next.state = COCC_ST_IDLE;
					st_next.ready = 1'b1;
				end
			end
			COCC_ST_ZERO: begin
				// one capability-width zero store per beat, each clearing its tag
				if (mem_ready_in) begin
					if (st_reg.beat == CNT_W'(BEATS - 1)) begin
						st_next.mem.valid = 1'b0;
						st_next.done = 1'b1;
						st_next.state = COCC_ST_IDLE;
						st_next.ready = 1'b1;
					end else begin
						st_next.beat = st_reg.beat + CNT_W'(1);
						st_next.mem.addr = st_reg.mem.addr + ADDR_W'(CAP_BYTES);
					end
				end
			end
			default: begin
				st_next = '0;
				st_next.ready = 1'b1;
			end
		endcase
	end

	always_ff @(posedge sys_clk_in or negedge rst_sync_reg) begin
		if (!rst_sync_reg) begin
			st_reg <= '{
				state:   COCC_ST_IDLE,
				beat:    '0,
				blk:     '0,
				mem:     '0,
				ready:   1'b1,
				done:    1'b0,
				exc:     COCC_EXC_NONE,
				dropped: 1'b0
			};
		end else begin
			st_reg <= st_next;
		end
	end

	assign req_ready_out    = st_reg.ready;
	assign mem_out          = st_reg.mem;
	assign done_out         = st_reg.done;
	assign exc_out          = st_reg.exc;
	assign pref_dropped_out = st_reg.dropped;
endmodule // cocc_checker

// sorts a request into its operation class
module cocc_op_decode import cocc_pkg::*; (
	input  wire cocc_op_t op_in,
	output logic          pref_out,
	output logic          clean_out,
	output logic          inval_out,
	output logic          zero_out
);
	assign pref_out  = (op_in == COCC_OP_PREF_I) || (op_in == COCC_OP_PREF_R)
		|| (op_in == COCC_OP_PREF_W);
	assign clean_out = op_in == COCC_OP_CLEAN;
	assign inval_out = op_in == COCC_OP_INVAL;
	assign zero_out  = op_in == COCC_OP_ZERO;
endmodule // cocc_op_decode

// overlap and containment of one address span against capability bounds
module cocc_span_cmp import cocc_pkg::*; #(
	parameter int ADDR_W_P = ADDR_W
) (
	input  wire logic [ADDR_W_P-1:0] lo_in,
	input  wire logic [ADDR_W_P-1:0] hi_in,
	input  wire logic [ADDR_W_P-1:0] base_in,
	input  wire logic [ADDR_W_P-1:0] top_in,
	input  wire logic                decodable_in,
	output logic                     any_out,
	output logic                     all_out
);
	logic lo_below_top;
	logic hi_above_base;
	logic lo_from_base;
	logic hi_to_top;

	assign lo_below_top  = lo_in < top_in;
	assign hi_above_base = hi_in > base_in;
	assign lo_from_base  = lo_in >= base_in;
	assign hi_to_top     = hi_in <= top_in;
	// undecodable bounds count as no byte in bounds
	assign any_out = decodable_in && lo_below_top && hi_above_base;
	assign all_out = decodable_in && lo_from_base && hi_to_top;
endmodule // cocc_span_cmp

// authorisation of one prefetch hint; a failed gate only drops the access
module cocc_pref_gate import cocc_pkg::*; (
	input  wire cocc_op_t op_in,
	input  wire logic     cap_ok_in,
	input  wire logic     any_in,
	input  wire logic     imm_ok_in,
	input  wire logic     perm_r_in,
	input  wire logic     perm_w_in,
	input  wire logic     perm_x_in,
	output logic          ok_out
);
	logic base_ok;
	logic perm_ok;

	assign base_ok = cap_ok_in && any_in && imm_ok_in;

	always_comb begin
		case (op_in)
			COCC_OP_PREF_I: perm_ok = perm_x_in;
			COCC_OP_PREF_R: perm_ok = perm_r_in;
			COCC_OP_PREF_W: perm_ok = perm_w_in;
			default:        perm_ok = 1'b0;
		endcase
	end

	assign ok_out = base_ok && perm_ok;
endmodule // cocc_pref_gate
`default_nettype wire

// [cocc_pkg.sv]
// package for the cache-operation capability checker
`default_nettype none
package cocc_pkg;
	localparam int ADDR_W      = 64;
	localparam int CAP_W_BITS  = 128;
	localparam int CBLK_BYTES  = 64;
	localparam int IMM_W       = 12;
	localparam int IMM_LOW_W   = 5;
	localparam logic [IMM_LOW_W-1:0] IMM_LOW_ZERO = 5'h00;
	localparam int ZERO_CYCLES = CBLK_BYTES / (CAP_W_BITS / 8);

	typedef enum logic [2:0] {
		COCC_OP_CLEAN  = 3'h0,
		COCC_OP_FLUSH  = 3'h1,
		COCC_OP_INVAL  = 3'h2,
		COCC_OP_ZERO   = 3'h3,
		COCC_OP_PREF_I = 3'h4,
		COCC_OP_PREF_R = 3'h5,
		COCC_OP_PREF_W = 3'h6
	} cocc_op_t;

	typedef enum logic [2:0] {
		COCC_CMD_NONE  = 3'h0,
		COCC_CMD_CLEAN = 3'h1,
		COCC_CMD_FLUSH = 3'h2,
		COCC_CMD_INVAL = 3'h3,
		COCC_CMD_ZERO  = 3'h4,
		COCC_CMD_PREF  = 3'h5
	} cocc_cmd_t;

	typedef enum logic [1:0] {
		COCC_EXC_NONE  = 2'h0,
		COCC_EXC_STORE = 2'h1,
		COCC_EXC_ILL   = 2'h2
	} cocc_exc_t;

	// authorizing capability as decoded by the core
	typedef struct packed {
		logic              tag;
		logic              sealed;
		logic              perm_r;
		logic              perm_w;
		logic              perm_x;
		logic              integrity_ok;
		logic              bounds_ok;
		logic [ADDR_W-1:0] base;
		logic [ADDR_W-1:0] top;
		logic [ADDR_W-1:0] address;
	} cocc_cap_t;

	typedef struct packed {
		logic              valid;
		cocc_op_t          op;
		logic [IMM_W-1:0]  imm;
		logic              pc_system_register_access_perm;
		logic              less_priv;
		logic              inval_as_flush_csr;
		logic              pma_tag_fault;
		logic              zero_store_tag;
		cocc_cap_t         cap;
	} cocc_req_t;

	typedef struct packed {
		logic              valid;
		cocc_cmd_t         cmd;
		logic [ADDR_W-1:0] addr;
		logic              clear_tag;
	} cocc_mem_t;
endpackage
`default_nettype wire

// [cocc_mem_model.sv]
// cache and memory stand-in that accepts commands promptly or after a stall
`default_nettype none
module cocc_mem_model import cocc_pkg::*; (
	input  wire logic      clk_in,
	input  wire logic      rst_b_in,
	input  wire cocc_mem_t mem_in,
	input  wire logic      slow_in,
	output logic           ready_out
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [1:0] wait_reg;
	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			wait_reg  <= 2'h0;
			ready_out <= 1'b0;
		end else begin
			wait_reg  <= mem_in.valid ? wait_reg + 2'h1 : 2'h0;
			ready_out <= mem_in.valid && !ready_out && (!slow_in || wait_reg == 2'h3);
		end
	end
endmodule // cocc_mem_model
`default_nettype wire

// [cocc_prop_checker.sv]
// assertions on the ports of the cache-op capability checker
`default_nettype none
module cocc_prop_checker import cocc_pkg::*; (
	input wire logic      sys_clk_in,
	input wire logic      rst_b_in,
	input wire cocc_req_t req_in,
	input wire logic      mem_ready_in,
	input wire logic      req_ready_out,
	input wire cocc_mem_t mem_out,
	input wire logic      done_out,
	input wire cocc_exc_t exc_out,
	input wire logic      pref_dropped_out
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge sys_clk_in); endclocking
	default disable iff (!rst_b_in);
	wire               tk  = req_in.valid && req_ready_out;
	wire               pf  = req_in.op >= COCC_OP_PREF_I;
	wire               pcp = req_in.pc_system_register_access_perm;
	wire               bad = !req_in.cap.tag || req_in.cap.sealed || !req_in.cap.integrity_ok;
	logic              pf_reg;
	logic [ADDR_W-1:0] a_reg;
	always_ff @(posedge sys_clk_in) begin
		if (tk)
			pf_reg <= pf;
		if (mem_out.valid && mem_ready_in)
			a_reg <= mem_out.addr;
	end
	sequence zbeat;
		mem_out.valid && mem_ready_in && mem_out.cmd == COCC_CMD_ZERO && mem_out.addr[5:4] != 2'h3;
	endsequence
	chk_auth_fault:
		assert property (tk && !pf && pcp && bad |=> done_out && exc_out == COCC_EXC_STORE)
		else $error("no store fault");
	chk_ill_inval:
		assert property (tk && req_in.op == COCC_OP_INVAL && !pcp |=> exc_out == COCC_EXC_ILL)
		else $error("no illegal trap");
	chk_fault_direct:
		assert property (done_out && exc_out != COCC_EXC_NONE |-> $past(tk))
		else $error("late fault");
	chk_pref_quiet:
		assert property (done_out && pf_reg |-> exc_out == COCC_EXC_NONE)
		else $error("prefetch trapped");
	chk_pref_skip:
		assert property (tk && pf && bad |=> pref_dropped_out && !mem_out.valid)
		else $error("prefetch issued");
	chk_inval_flush:
		assert property (mem_out.valid |-> mem_out.cmd != COCC_CMD_INVAL)
		else $error("inval issued");
	chk_zero_tag:
		assert property (mem_out.valid && mem_out.cmd == COCC_CMD_ZERO
			|-> mem_out.clear_tag && mem_out.addr[3:0] == 4'h0) else $error("bad zero beat");
	chk_zero_step:
		assert property (zbeat |=> ##[0:2] mem_out.valid && mem_out.addr == a_reg + 64'h10)
		else $error("zero beat skipped");
endmodule // cocc_prop_checker
bind cocc_checker cocc_prop_checker u_cocc_prop_checker (
	.sys_clk_in(sys_clk_in), .rst_b_in(rst_b_in), .req_in(req_in), .mem_ready_in(mem_ready_in),
	.req_ready_out(req_ready_out), .mem_out(mem_out), .done_out(done_out), .exc_out(exc_out),
	.pref_dropped_out(pref_dropped_out));
`default_nettype wire

// [tb_top.sv]
// self-checking bench for the cache-op capability checker
`default_nettype none
module tb_top import cocc_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct packed {
		logic [2:0]  op;
		logic [8:0]  f;
		logic [15:0] a;
		logic [2:0]  c;
		logic [1:0]  e;
	} cocc_row_t;
	logic      sys_clk_in, rst_b_in, mem_ready_in, req_ready_out, done_out, drop, slow;
	cocc_req_t req_in;
	cocc_mem_t mem_out;
	cocc_exc_t exc_out;
	int        fail_count, tests_run;
	// flags: pc perm, pma fault, tag, sealed, r, w, x, integrity, decodable
	cocc_row_t rows [18] = '{
		'{3'h0, 9'h15f, 16'h1040, 3'h1, 2'h0}, '{3'h0, 9'h15f, 16'h1000, 3'h1, 2'h0},
		'{3'h1, 9'h15f, 16'h1080, 3'h0, 2'h1}, '{3'h2, 9'h15f, 16'h1040, 3'h2, 2'h0},
		'{3'h2, 9'h15f, 16'h1000, 3'h0, 2'h1}, '{3'h2, 9'h05f, 16'h1040, 3'h0, 2'h2},
		'{3'h0, 9'h11f, 16'h1040, 3'h0, 2'h1}, '{3'h1, 9'h17f, 16'h1040, 3'h0, 2'h1},
		'{3'h0, 9'h157, 16'h1040, 3'h0, 2'h1}, '{3'h2, 9'h14f, 16'h1040, 3'h0, 2'h1},
		'{3'h1, 9'h15d, 16'h1040, 3'h0, 2'h1}, '{3'h3, 9'h15f, 16'h1040, 3'h4, 2'h0},
		'{3'h3, 9'h15f, 16'h1048, 3'h0, 2'h1}, '{3'h3, 9'h1df, 16'h1040, 3'h0, 2'h1},
		'{3'h4, 9'h15f, 16'h1080, 3'h5, 2'h0}, '{3'h4, 9'h15b, 16'h1080, 3'h0, 2'h0},
		'{3'h5, 9'h14f, 16'h1080, 3'h0, 2'h0}, '{3'h6, 9'h157, 16'h1080, 3'h0, 2'h0}};
	cocc_checker u_cocc_checker (.sys_clk_in(sys_clk_in), .rst_b_in(rst_b_in), .req_in(req_in),
		.mem_ready_in(mem_ready_in), .req_ready_out(req_ready_out), .mem_out(mem_out),
		.done_out(done_out), .exc_out(exc_out), .pref_dropped_out(drop));
	cocc_mem_model u_cocc_mem_model (.clk_in(sys_clk_in), .rst_b_in(rst_b_in), .mem_in(mem_out),
		.slow_in(slow), .ready_out(mem_ready_in));
	task automatic chk(input string n, input logic [63:0] e, input logic [63:0] g);
		tests_run++;
		if (g !== e) begin
			fail_count++;
			$display("CHECK FAILED %s expected %0h seen %0h", n, e, g);
		end
	endtask
	task automatic conclude;
		$display("checks %0d failures %0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic run(input cocc_row_t r);
		int          n;
		logic [11:0] im;
		logic [63:0] ea;
		n  = 0;
		im = (r.op > 3'h3) ? 12'hfc0 : 12'h000;
		ea = {48'h0, r.a} + {{52{im[11]}}, im};
		@(posedge sys_clk_in);
		req_in <= '{1'b1, cocc_op_t'(r.op), im, r.f[8], 1'b1, 1'b0, r.f[7], 1'b1, '{r.f[6],
			r.f[5], r.f[4], r.f[3], r.f[2], r.f[1], r.f[0], 64'h1020, 64'h1080, {48'h0, r.a}}};
		@(posedge sys_clk_in);
		req_in.valid <= 1'b0;
		repeat (30) begin
			@(negedge sys_clk_in);
			if (mem_out.valid && mem_ready_in) begin
				chk("cmd", r.c, mem_out.cmd);
				chk("addr", ea + 16 * n, mem_out.addr);
				n++;
			end
			if (done_out || (n > 0 && r.c == 3'h5))
				break;
		end
		chk("beats", (r.c == 3'h4) ? 4 : (r.c != 3'h0), n);
		if (r.c != 3'h5) begin
			chk("done", 1, done_out);
			chk("exc", r.e, exc_out);
			chk("drop", r.op > 3'h3, drop);
		end
	endtask
	initial begin
		sys_clk_in = 1'b0;
		forever #10 sys_clk_in = ~sys_clk_in;
	end
	initial begin
		repeat (4000) @(posedge sys_clk_in);
		fail_count++;
		conclude;
	end
	initial begin
		rst_b_in = 1'b0;
		slow = 1'b0;
		req_in = '0;
		repeat (10) @(posedge sys_clk_in);
		chk("rst ready", 1, req_ready_out);
		chk("rst mem", 0, mem_out.valid);
		rst_b_in <= 1'b1;
		repeat (3) @(posedge sys_clk_in);
		foreach (rows[i]) run(rows[i]);
		// memory stalls each beat
		slow <= 1'b1;
		run(rows[11]);
		run(rows[3]);
		slow <= 1'b0;
		run('{3'h5, 9'h11f, 16'h1080, 3'h0, 2'h0});
		run('{3'h6, 9'h15f, 16'h1100, 3'h0, 2'h0});
		conclude;
	end
endmodule // tb_top
`default_nettype wire
